// ---- rtl/alarm_map.vh ----
// Register offsets, field positions, reset values and timing counts of the alarm block.
// What this block does
// - Results are presented as unsigned straight binary, bipolar ranges included.
// - A result is an 18-bit code; one step is span over two^18.
// - Alarm drives the multifunction pin only when pin config field equals 01b.
// - Input alarm raised when the code lies beyond high or low threshold.
// - Supply alarm raised when the comparator reports supply above or below trips.
// - Input and supply alarms enabled by default, each with its own disable bit.
// - Each alarm source keeps active and tripped flags, both set on trigger.
// - Active flags are cleared each end of conversion and reset if still true.
// - Tripped flags hold until the flag register is read; the read clears them.
// - Flags update at each conversion end; active flags, when selected, are readable in any serial frame.
// - Alarm pin goes high on any supply or input over/undervoltage condition.
// - Data output control selects alarm flags appended to the serial stream.
// - High and low thresholds are separate; one hysteresis value is shared.
// - Input high alarm sets when code is strictly above high threshold.
// - Input high alarm clears only when code <= high threshold - hyst - 1.
// - Input low alarm sets when code is strictly below low threshold.
// - Input low alarm clears only when code >= low threshold + hyst + 1.
// - Each frame shifts data in and out together through one 32-bit register.
// - Host writes in standard SPI mode; output clocking belongs to the interface.
// - Rising convert-start select starts a conversion whose result the alarms check.
`ifndef ALARM_MAP_VH
`define ALARM_MAP_VH
`define OUT_CTL_OFS      8'h00
`define PWR_CTL_OFS      8'h04
`define DOUT_CTL_OFS     8'h08
`define HIGH_TH_OFS      8'h0C
`define LOW_TH_OFS       8'h10
`define FLAG_OFS         8'h14
`define RESULT_OFS       8'h18
`define RX_WORD_OFS      8'h1C
`define CODE_W           18
`define FRAME_W          32
`define PIN_CFG_ALARM    2'h1
`define HYST_LSB         20
`define HYST_W           8
`define IN_DIS_BIT       8
`define VDD_DIS_BIT      9
`define APP_IN_BIT       0
`define APP_VDD_BIT      1
`define BIPOLAR_BIT      16
`define CLK_PERIOD_NS    40
`define CONV_TIME_NS     1000
`define CONV_CYCLES      ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HIGH_TH_RESET    18'h3FFFF
`define LOW_TH_RESET     18'h00000
`define HTRANS_NONSEQ    2'h2
`endif

// ---- rtl/adc_alarm_and_result_coding.v ----
// Alarm evaluation, result coding, serial frame shifter and AHB-Lite register file.
`timescale 1ns/10ps
`include "alarm_map.vh"

module adc_alarm_and_result_coding
(
  input  wire        core_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [17:0] raw_code,
  input  wire        supply_high_cmp,
  input  wire        supply_low_cmp,
  input  wire        convert_start_select,
  input  wire        sclk,
  input  wire        sdi,
  output reg         sdo,
  output reg         sdo_oe,
  output reg         alarm_multifunction_pin,
  output reg         conversion_busy
);

  localparam ST_ACQ  = 2'b01;
  localparam ST_CONV = 2'b10;
  localparam [31:0] CONV_LEN = `CONV_CYCLES;

  // Converts the core's raw code; bipolar codes arrive two's complement.
  function [17:0] to_straight;
    input [17:0] code;
    input        bipolar;
    begin
      to_straight = bipolar ? {~code[17], code[16:0]} : code;
    end
  endfunction

  // Common decode for both bus phases.
  function word_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      word_hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.
  reg  [1:0]  cs_sync_reg;
  reg  [1:0]  sclk_sync_reg;
  reg  [1:0]  sdi_sync_reg;
  reg  [1:0]  vhi_sync_reg;
  reg  [1:0]  vlo_sync_reg;
  reg         cs_last_reg;
  reg         sclk_last_reg;
  wire        cs_now;
  wire        sclk_now;
  wire        cs_rise;
  wire        cs_fall;
  wire        sclk_rise;
  wire        sclk_fall;

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_sync_reg   <= 2'h3;
      sclk_sync_reg <= 2'h0;
      sdi_sync_reg  <= 2'h0;
      vhi_sync_reg  <= 2'h0;
      vlo_sync_reg  <= 2'h0;
      cs_last_reg   <= 1'b1;
      sclk_last_reg <= 1'b0;
    end
    else
    begin
      cs_sync_reg   <= {cs_sync_reg[0], convert_start_select};
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdi};
      vhi_sync_reg  <= {vhi_sync_reg[0], supply_high_cmp};
      vlo_sync_reg  <= {vlo_sync_reg[0], supply_low_cmp};
      cs_last_reg   <= cs_sync_reg[1];
      sclk_last_reg <= sclk_sync_reg[1];
    end
  end

  assign cs_now    = cs_sync_reg[1];
  assign sclk_now  = sclk_sync_reg[1];
  assign cs_rise   = cs_now & ~cs_last_reg;
  assign cs_fall   = ~cs_now & cs_last_reg;
  assign sclk_rise = ~cs_now & sclk_now & ~sclk_last_reg;
  assign sclk_fall = ~cs_now & ~sclk_now & sclk_last_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers and bus slave.
  reg  [1:0]  pin_cfg_reg;
  reg         in_dis_reg;
  reg         vdd_dis_reg;
  reg  [1:0]  append_sel_reg;
  reg         bipolar_reg;
  reg  [17:0] high_th_reg;
  reg  [17:0] low_th_reg;
  reg  [7:0]  hyst_reg;
  reg  [7:0]  wr_addr_reg;
  reg         wr_pend_reg;
  reg  [31:0] rd_next;
  wire        bus_req;
  wire        flag_read;

  assign bus_req   = hsel & hready & (htrans == `HTRANS_NONSEQ);
  // The read clears tripped flags in the address phase; data shows their prior value.
  assign flag_read = bus_req & ~hwrite & word_hit(haddr, `FLAG_OFS);
  reg  [17:0] result_reg;
  reg  [31:0] rx_word_reg;
  reg         in_hi_act_reg;
  reg         in_lo_act_reg;
  reg         vdd_hi_act_reg;
  reg         vdd_lo_act_reg;
  reg         in_hi_trip_reg;
  reg         in_lo_trip_reg;
  reg         vdd_hi_trip_reg;
  reg         vdd_lo_trip_reg;

  always @*
  begin
    rd_next = 32'h00000000;
    case ({2'b00, haddr[7:2]})
      `OUT_CTL_OFS >> 2:
        rd_next[1:0] = pin_cfg_reg;
      `PWR_CTL_OFS >> 2:
      begin
        rd_next[`IN_DIS_BIT]  = in_dis_reg;
        rd_next[`VDD_DIS_BIT] = vdd_dis_reg;
      end
      `DOUT_CTL_OFS >> 2:
      begin
        rd_next[1:0]          = append_sel_reg;
        rd_next[`BIPOLAR_BIT] = bipolar_reg;
      end
      `HIGH_TH_OFS >> 2:
      begin
        rd_next[17:0]                         = high_th_reg;
        rd_next[`HYST_LSB+`HYST_W-1:`HYST_LSB] = hyst_reg;
      end
      `LOW_TH_OFS >> 2:
        rd_next[17:0] = low_th_reg;
      `FLAG_OFS >> 2:
        rd_next[7:0] = {vdd_lo_trip_reg, vdd_hi_trip_reg, in_lo_trip_reg, in_hi_trip_reg,
                        vdd_lo_act_reg, vdd_hi_act_reg, in_lo_act_reg, in_hi_act_reg};
      `RESULT_OFS >> 2:
        rd_next[17:0] = result_reg;
      `RX_WORD_OFS >> 2:
        rd_next = rx_word_reg;
      default:
        rd_next = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      hrdata         <= 32'h00000000;
      hreadyout      <= 1'b1;
      hresp          <= 1'b0;
      wr_addr_reg    <= 8'h00;
      wr_pend_reg    <= 1'b0;
      pin_cfg_reg    <= 2'h0;
      in_dis_reg     <= 1'b0;
      vdd_dis_reg    <= 1'b0;
      append_sel_reg <= 2'h0;
      bipolar_reg    <= 1'b1;
      high_th_reg    <= `HIGH_TH_RESET;
      low_th_reg     <= `LOW_TH_RESET;
      hyst_reg       <= 8'h00;
    end
    else
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= bus_req & hwrite;
      if (bus_req)
        wr_addr_reg <= haddr;
      if (bus_req & ~hwrite)
        hrdata <= rd_next;
      if (wr_pend_reg)
      begin
        if (word_hit(wr_addr_reg, `OUT_CTL_OFS))
          pin_cfg_reg <= hwdata[1:0];
        if (word_hit(wr_addr_reg, `PWR_CTL_OFS))
        begin
          in_dis_reg  <= hwdata[`IN_DIS_BIT];
          vdd_dis_reg <= hwdata[`VDD_DIS_BIT];
        end
        if (word_hit(wr_addr_reg, `DOUT_CTL_OFS))
        begin
          append_sel_reg <= hwdata[1:0];
          bipolar_reg    <= hwdata[`BIPOLAR_BIT];
        end
        if (word_hit(wr_addr_reg, `HIGH_TH_OFS))
        begin
          high_th_reg <= hwdata[17:0];
          hyst_reg    <= hwdata[`HYST_LSB+`HYST_W-1:`HYST_LSB];
        end
        if (word_hit(wr_addr_reg, `LOW_TH_OFS))
          low_th_reg <= hwdata[17:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer.
  reg  [1:0]  state_reg;
  reg  [7:0]  conv_cnt_reg;
  reg         eoc_reg;

  // Edges on the select input are ignored until the running conversion ends.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg       <= ST_ACQ;
      conv_cnt_reg    <= 8'h00;
      eoc_reg         <= 1'b0;
      conversion_busy <= 1'b0;
    end
    else
    begin
      eoc_reg <= 1'b0;
      case (state_reg)
        ST_ACQ:
          if (cs_rise)
          begin
            state_reg       <= ST_CONV;
            conv_cnt_reg    <= CONV_LEN[7:0] - 8'h01;
            conversion_busy <= 1'b1;
          end
        ST_CONV:
          if (conv_cnt_reg == 8'h00)
          begin
            state_reg       <= ST_ACQ;
            eoc_reg         <= 1'b1;
            conversion_busy <= 1'b0;
          end
          else
            conv_cnt_reg <= conv_cnt_reg - 8'h01;
        default:
          state_reg <= ST_ACQ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result coding and alarm flags.
  wire [17:0] new_code;
  wire [19:0] code_x;
  wire [19:0] hi_clear_lim;
  wire [19:0] lo_clear_lim;
  wire        hi_set;
  wire        hi_clr;
  wire        lo_set;
  wire        lo_clr;
  wire        hi_next;
  wire        lo_next;
  wire        vhi_next;
  wire        vlo_next;

  assign new_code = to_straight(raw_code, bipolar_reg);
  // Limits are signed 20-bit so a hysteresis larger than the threshold cannot wrap.
  assign code_x       = {2'b00, new_code};
  assign hi_clear_lim = {2'b00, high_th_reg} - {12'h000, hyst_reg} - 20'h00001;
  assign lo_clear_lim = {2'b00, low_th_reg} + {12'h000, hyst_reg} + 20'h00001;
  assign hi_set   = new_code > high_th_reg;
  assign hi_clr   = ~hi_clear_lim[19] & (code_x <= hi_clear_lim);
  assign lo_set   = new_code < low_th_reg;
  assign lo_clr   = code_x >= lo_clear_lim;
  // Hysteresis: a set alarm stays until its clear limit is reached.
  assign hi_next  = ~in_dis_reg & (hi_set | (in_hi_act_reg & ~hi_clr));
  assign lo_next  = ~in_dis_reg & (lo_set | (in_lo_act_reg & ~lo_clr));
  assign vhi_next = ~vdd_dis_reg & vhi_sync_reg[1];
  assign vlo_next = ~vdd_dis_reg & vlo_sync_reg[1];

  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      result_reg      <= 18'h00000;
      in_hi_act_reg   <= 1'b0;
      in_lo_act_reg   <= 1'b0;
      vdd_hi_act_reg  <= 1'b0;
      vdd_lo_act_reg  <= 1'b0;
      in_hi_trip_reg  <= 1'b0;
      in_lo_trip_reg  <= 1'b0;
      vdd_hi_trip_reg <= 1'b0;
      vdd_lo_trip_reg <= 1'b0;
      alarm_multifunction_pin <= 1'b0;
    end
    else
    begin
      if (eoc_reg)
      begin
        result_reg     <= new_code;
        in_hi_act_reg  <= hi_next;
        in_lo_act_reg  <= lo_next;
        vdd_hi_act_reg <= vhi_next;
        vdd_lo_act_reg <= vlo_next;
      end
      // A trigger in the same cycle as the clearing read keeps the flag set.
      in_hi_trip_reg  <= (eoc_reg & hi_next) | (in_hi_trip_reg & ~flag_read);
      in_lo_trip_reg  <= (eoc_reg & lo_next) | (in_lo_trip_reg & ~flag_read);
      vdd_hi_trip_reg <= (eoc_reg & vhi_next) | (vdd_hi_trip_reg & ~flag_read);
      vdd_lo_trip_reg <= (eoc_reg & vlo_next) | (vdd_lo_trip_reg & ~flag_read);
      alarm_multifunction_pin <= (pin_cfg_reg == `PIN_CFG_ALARM) &
                                 (in_hi_act_reg | in_lo_act_reg |
                                  vdd_hi_act_reg | vdd_lo_act_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame: one 32-bit register, loaded at frame start, shifted both ways.
  reg  [31:0] frame_reg;
  reg  [31:0] frame_load;

  always @*
  begin
    frame_load = {result_reg, 14'h0000};
    if (append_sel_reg[`APP_IN_BIT])
      frame_load[13:12] = {in_hi_act_reg, in_lo_act_reg};
    if (append_sel_reg[`APP_VDD_BIT])
      frame_load[11:10] = {vdd_hi_act_reg, vdd_lo_act_reg};
  end

  // Mode 0: capture on the rising SCLK edge, launch on the falling one.
  always @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      frame_reg   <= 32'h00000000;
      rx_word_reg <= 32'h00000000;
      sdo         <= 1'b0;
      sdo_oe      <= 1'b0;
    end
    else
    begin
      if (cs_fall)
      begin
        frame_reg <= frame_load;
        sdo       <= frame_load[31];
        sdo_oe    <= 1'b1;
      end
      else if (sclk_rise)
        frame_reg <= {frame_reg[30:0], sdi_sync_reg[1]};
      else if (sclk_fall)
        sdo <= frame_reg[31];
      if (cs_rise)
      begin
        rx_word_reg <= frame_reg;
        sdo_oe      <= 1'b0;
      end
    end
  end

endmodule

// ---- tb/adc_alarm_and_result_coding_properties.sv ----
// Port-level assertions of the alarm and result-coding block.
`timescale 1ns/10ps
module alarm_checker
(
  input wire        core_clk,
  input wire        rst,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        convert_start_select,
  input wire        sdo_oe,
  input wire        alarm_multifunction_pin,
  input wire        conversion_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  ready_high_a: assert property (hreadyout)
    else $error("wait state seen");
  resp_okay_a: assert property (!hresp)
    else $error("error response seen");
  rdata_hold_a: assert property (
    !(hsel && htrans == 2'h2 && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  oe_open_a: assert property (
    $fell(convert_start_select) && !conversion_busy |-> ##[1:5] sdo_oe)
    else $error("frame not opened");
  oe_close_a: assert property (convert_start_select [*5] |-> !sdo_oe)
    else $error("output enabled outside frame");
  conv_start_a: assert property (
    $rose(convert_start_select) && !conversion_busy |-> ##[1:5] conversion_busy)
    else $error("conversion did not start");
  conv_length_a: assert property (
    $rose(conversion_busy) |-> conversion_busy [*8] ##1 conversion_busy [*8] ##1
      conversion_busy [*8] ##1 conversion_busy ##1 !conversion_busy)
    else $error("conversion length wrong");
  reset_quiet_a: assert property (
    $fell(rst) |-> !sdo_oe && !conversion_busy && !alarm_multifunction_pin)
    else $error("outputs active after reset");
  pin_steady_a: assert property ($changed(alarm_multifunction_pin) |-> !conversion_busy)
    else $error("alarm pin moved during conversion");
endmodule

// ---- tb/spi_host_model.sv ----
// Serial host that runs one mode-0 frame of 32 bits on the converter's link.
`timescale 1ns/10ps
module spi_host_model
(
  input  wire core_clk,
  input  wire sdo,
  output reg  convert_start_select,
  output reg  sclk,
  output reg  sdi
);
  initial
  begin
    convert_start_select = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  ////////////////////////////////////////////////////////////
  // Four core clocks per half period give the 320 ns link clock.
  task half;
    repeat (4) @(posedge core_clk);
  endtask
  // The link clock stands low between frames; sdo is taken late in the high phase.
  task frame(input [31:0] tx, output [31:0] rx);
    integer b;
    begin
      convert_start_select <= 1'b0;
      for (b = 31; b >= 0; b = b - 1)
      begin
        sdi <= tx[b];
        half;
        sclk <= 1'b1;
        half;
        rx[b] = sdo;
        sclk <= 1'b0;
      end
      half;
      sdi <= ~tx[0];
      convert_start_select <= 1'b1;
    end
  endtask
endmodule

// ---- tb/test_adc_alarm_and_result_coding.sv ----
// Self-checking bench of the alarm and result-coding block.
`timescale 1ns/10ps
`include "alarm_map.vh"
module test_adc_alarm_and_result_coding;
  reg         core_clk = 1'b0;
  reg         rst = 1'b1;
  reg         hsel = 1'b0;
  reg         hwrite = 1'b0;
  reg  [7:0]  haddr = 8'h00;
  reg  [1:0]  htrans = 2'h0;
  reg  [31:0] hwdata = 32'h0;
  reg  [17:0] raw_code = 18'h0;
  reg         supply_high_cmp = 1'b0;
  reg         supply_low_cmp = 1'b0;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, convert_start_select, sclk, sdi, sdo, sdo_oe;
  wire        alarm_multifunction_pin, conversion_busy;
  integer     n_mismatch = 0;
  integer     check_count = 0;
  integer     seed = 32'hD3555FF9;
  integer     i, s, th, tl, hy;
  reg  [31:0] k, q, tx, rx;
  reg  [17:0] res = 18'h0;
  reg  [3:0]  act = 4'h0;
  reg  [3:0]  trip = 4'h0;
  reg  [3:0]  shown;
  reg         hi_st = 1'b0;
  reg         lo_st = 1'b0;
  reg  [1:0]  pcfg, app;
  reg         bip, vdis, idis;

  always #20 core_clk = ~core_clk;

  adc_alarm_and_result_coding u_adc_alarm_and_result_coding
  (
    .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .raw_code, .supply_high_cmp,
    .supply_low_cmp, .convert_start_select, .sclk, .sdi, .sdo, .sdo_oe,
    .alarm_multifunction_pin, .conversion_busy
  );
  spi_host_model u_spi_host_model
  (
    .core_clk, .sdo, .convert_start_select, .sclk, .sdi
  );
  ////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h0);
      chk(q, e);
    end
  endtask
  task finish_test;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_mismatch = n_mismatch + 1;
    finish_test;
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(`HIGH_TH_OFS, 32'h0003FFFF);
    rd(`LOW_TH_OFS, 32'h0);
    rd(`DOUT_CTL_OFS, 32'h00010000);
    rd(`OUT_CTL_OFS, 32'h0);
    rd(`PWR_CTL_OFS, 32'h0);
    wr(`FLAG_OFS, 32'hFF);
    rd(`FLAG_OFS, 32'h0);
    rd(8'h40, 32'h0);
    $display("reset values checked");
    th = 32'h28000 + ($random(seed) & 32'h3FFF);
    tl = 32'h18000 - ($random(seed) & 32'h3FFF);
    hy = $random(seed) & 32'hFF;
    wr(`HIGH_TH_OFS, (hy << 20) | th);
    wr(`LOW_TH_OFS, tl);
    rd(`HIGH_TH_OFS, (hy << 20) | th);
    $display("thresholds set");
    for (i = 0; i < 60; i = i + 1)
    begin
      k = $random(seed);
      pcfg = (k[3:2] == 2'h0) ? 2'h2 : 2'h1;
      vdis = k[4] & k[5];
      idis = (i == 59);
      bip = k[6];
      app = k[17:16];
      case (k[11:8])
        4'h0: s = th + 1;
        4'h1: s = th;
        4'h2: s = th - hy - 1;
        4'h3: s = th - hy;
        4'h4: s = tl - 1;
        4'h5: s = tl;
        4'h6: s = tl + hy;
        4'h7: s = tl + hy + 1;
        default: s = $random(seed) & 32'h3FFFF;
      endcase
      wr(`OUT_CTL_OFS, pcfg);
      wr(`PWR_CTL_OFS, {vdis, idis, 8'h0});
      wr(`DOUT_CTL_OFS, {bip, 14'h0, app});
      // Bipolar codes leave the core in two's complement; the top bit flips back.
      raw_code <= s[17:0] ^ {bip, 17'h0};
      supply_high_cmp <= k[12] & k[13];
      supply_low_cmp <= k[14] & k[15];
      tx = $random(seed);
      u_spi_host_model.frame(tx, rx);
      // The frame carries the previous conversion, with only the selected flag pairs shown.
      shown = act & {app[1], app[1], app[0], app[0]};
      chk(rx, {res, shown[0], shown[1], shown[2], shown[3], 10'h0});
      // Sync, the 25 busy cycles and the flag-to-pin stage all fit in this wait.
      repeat (40) @(posedge core_clk);
      hi_st = hi_st ? (s + hy + 1 > th) : (s > th);
      lo_st = lo_st ? (s < tl + hy + 1) : (s < tl);
      act = {supply_low_cmp & !vdis, supply_high_cmp & !vdis, lo_st & !idis, hi_st & !idis};
      trip = trip | act;
      res = s[17:0];
      rd(`RESULT_OFS, res);
      rd(`RX_WORD_OFS, tx);
      chk(alarm_multifunction_pin, (pcfg == 2'h1) && (act != 4'h0));
      if (i[0])
      begin
        rd(`FLAG_OFS, {trip, act});
        trip = 4'h0;
      end
    end
    $display("conversions checked");
    finish_test;
  end
endmodule

bind adc_alarm_and_result_coding alarm_checker u_alarm_checker
(
  .core_clk, .rst, .hsel, .htrans, .hwrite, .hrdata, .hreadyout, .hresp,
  .convert_start_select, .sdo_oe, .alarm_multifunction_pin, .conversion_busy
);
